// File: logic/arm_seq_pkg.sv
// Constants and types shared by the arm and trigger sequencer controller.
// Assumes an 8-bit register window on the digitizer side, reached by byte
// offsets, and a 32-bit Avalon-MM slave window toward local software.
package arm_seq_pkg;

   // Digitizer byte register offsets.
   localparam logic [7:0] DEV_ABORT_ARM   = 8'h41;
   localparam logic [7:0] DEV_ARM_STATE   = 8'h43;
   localparam logic [7:0] DEV_ARM_SOURCE  = 8'h49;
   localparam logic [7:0] DEV_ARM_CONTROL = 8'h4B;
   localparam logic [7:0] DEV_TRIG_SELECT = 8'h4D;
   localparam logic [7:0] DEV_REF_SELECT  = 8'h4F;
   localparam logic [7:0] DEV_DELAY_HIGH  = 8'h51;
   localparam logic [7:0] DEV_DELAY_LOW   = 8'h53;
   localparam logic [7:0] DEV_COUNT_HIGH  = 8'h55;
   localparam logic [7:0] DEV_COUNT_LOW   = 8'h57;
   localparam logic [7:0] DEV_TRIG_NOW    = 8'h5D;

   // Digitizer field masks and status bit positions.
   localparam logic [7:0] ARM_HOLD_MASK    = 8'h04;
   localparam logic [7:0] DELAY_FINE_MASK  = 8'h01;
   localparam logic [7:0] TRIG_HOLD_MASK   = 8'h80;
   localparam logic [7:0] REF_KEEP_MASK    = 8'hF8;
   localparam int         STATE_ARMED_BIT  = 7;
   localparam int         STATE_PREARM_BIT = 5;
   localparam int         STATE_INIT_BIT   = 1;

   // Legal ranges of the 16-bit counts.
   localparam logic [15:0] DELAY_MAX = 16'hFFFE;
   localparam logic [15:0] COUNT_MIN = 16'h0001;

   // Software register byte addresses of the controller.
   localparam int          ADDR_W        = 5;
   localparam logic [4:0]  REG_COMMAND   = 5'h00;
   localparam logic [4:0]  REG_ARG_LOW   = 5'h04;
   localparam logic [4:0]  REG_ARG_HIGH  = 5'h08;
   localparam logic [4:0]  REG_OPTION    = 5'h0C;
   localparam logic [4:0]  REG_DEV_STATE = 5'h10;
   localparam logic [4:0]  REG_EVENTS    = 5'h14;
   localparam logic [4:0]  REG_MASK      = 5'h18;

   // Event bits of the sticky status and mask registers.
   localparam int EV_W       = 3;
   localparam int EV_DONE    = 0;
   localparam int EV_REFUSED = 1;
   localparam int EV_ARMED   = 2;

   typedef enum logic [3:0] {
      CMD_NOP,
      CMD_ARM_SOURCE,
      CMD_ARM_COUNT,
      CMD_ARM_DELAY,
      CMD_REF_SOURCE,
      CMD_TRIG_SOURCE,
      CMD_ARM_NOW,
      CMD_TRIG_NOW,
      CMD_ABORT,
      CMD_READ_STATE
   } command_t;

   typedef enum logic [2:0] {
      OP_END,
      OP_READ,
      OP_WRITE,
      OP_REFUSE,
      OP_SKIP
   } op_kind_t;

   typedef struct packed {
      op_kind_t   kind;
      logic [7:0] addr;
      logic [7:0] data;
   } dev_op_t;

   typedef struct packed {
      logic       strobe;
      logic       write;
      logic [7:0] addr;
      logic [7:0] wdata;
   } dev_req_t;

endpackage

// File: logic/arm_trigger_sequencer.sv
// Host-side controller that programs the arm and trigger sequencer of a
// two-channel digitizer through its byte registers.
// Assumes the digitizer answers each byte access with a four-phase
// strobe/acknowledge handshake and holds read data while acknowledging.
//
// Summary of operation
// [R1] Idle: write arm source register directly.
// [R2] Initiated: hold arm, write source, release.
// [R3] Arm count high then low, idle only.
// [R4] Device adds one reference cycle delay.
// [R5] Control bit 0 picks delay time base.
// [R6] Delay high byte, then low byte plus one.
// [R7] Reference select keeps bits seven to three.
// [R8] Trigger hold bit 7 brackets initiated changes.
// [R9] Reading the strobe register arms immediately.
// [R10] Armed status bit skips arm immediate.
// [R11] Pre-arm incomplete forbids arm immediate.
// [R12] Trigger-now write bracketed by trigger hold.
// [R13] Abort write bracketed by trigger hold.
// [R14] Initiate waits arm, arm waits trigger.
// [R15] Re-initiation: memory first, then timebase; no command here issues a re-initiation.
// [R16] Status bit 1 shows idle or initiated.
// [R17] Byte registers; counts complete after both bytes.
// [R18] Arms counted; idle after programmed count.
//
// Chosen here: register access over Avalon-MM.
module arm_trigger_sequencer (
   input  wire logic                    clock,
   input  wire logic                    srst,
   input  wire logic [4:0]              avsAddress,
   input  wire logic                    avsRead,
   input  wire logic                    avsWrite,
   input  wire logic [31:0]             avsWritedata,
   output logic      [31:0]             avsReaddata,
   output logic                         avsWaitrequest,
   output logic                         irq,
   output arm_seq_pkg::dev_req_t        devReq,
   input  wire logic [7:0]              devRdata,
   input  wire logic                    devAck
);
   import arm_seq_pkg::*;

   typedef enum logic [1:0] {
      S_IDLE,
      S_ISSUE,
      S_WAIT_ACK,
      S_WAIT_REL
   } seq_state_t;

   // Works out the digitizer access for one step of a command from the
   // status byte taken in step 0 and the byte read back in step 1.
   function automatic dev_op_t stepOp(
      input command_t    c,
      input logic [2:0]  s,
      input logic [7:0]  st,
      input logic [7:0]  rb,
      input logic [15:0] arg,
      input logic        fine
   );
      dev_op_t     o;
      logic        init;
      logic [15:0] plus;
      o    = '{OP_END, 8'h00, 8'h00};
      init = st[STATE_INIT_BIT];
      plus = arg + COUNT_MIN;
      if (s == 3'd0) begin
         // [R16] Idle check first.
         o = '{OP_READ, DEV_ARM_STATE, 8'h00};
      end else begin
         case (c)
            CMD_ARM_SOURCE: begin
               if (!init) begin
                  // [R1] Direct source write.
                  if (s == 3'd1)
                     o = '{OP_WRITE, DEV_ARM_SOURCE, arg[7:0]};
               end else begin
                  // [R2] Hold, write, release.
                  case (s)
                     3'd1: o = '{OP_READ, DEV_ARM_CONTROL, 8'h00};
                     3'd2: o = '{OP_WRITE, DEV_ARM_CONTROL,
                                 rb | ARM_HOLD_MASK};
                     3'd3: o = '{OP_WRITE, DEV_ARM_SOURCE, arg[7:0]};
                     3'd4: o = '{OP_WRITE, DEV_ARM_CONTROL,
                                 rb & ~ARM_HOLD_MASK};
                     default: o = '{OP_END, 8'h00, 8'h00};
                  endcase
               end
            end
            CMD_ARM_COUNT: begin
               // [R3] Idle only, high byte first.
               // [R17] Device takes count after both bytes.
               // [R18] Count ends the sequence on the device.
               if (init || arg < COUNT_MIN)
                  o = '{OP_REFUSE, 8'h00, 8'h00};
               else if (s == 3'd1)
                  o = '{OP_WRITE, DEV_COUNT_HIGH, arg[15:8]};
               else if (s == 3'd2)
                  o = '{OP_WRITE, DEV_COUNT_LOW, arg[7:0]};
            end
            CMD_ARM_DELAY: begin
               // [R5] Time base select.
               // [R6] Low byte plus one.
               // [R4] Covers the inherent cycle.
               if (init || arg > DELAY_MAX) begin
                  o = '{OP_REFUSE, 8'h00, 8'h00};
               end else begin
                  case (s)
                     3'd1: o = '{OP_READ, DEV_ARM_CONTROL, 8'h00};
                     3'd2: o = '{OP_WRITE, DEV_ARM_CONTROL,
                                 fine ? (rb | DELAY_FINE_MASK)
                                      : (rb & ~DELAY_FINE_MASK)};
                     3'd3: o = '{OP_WRITE, DEV_DELAY_HIGH, plus[15:8]};
                     3'd4: o = '{OP_WRITE, DEV_DELAY_LOW, plus[7:0]};
                     default: o = '{OP_END, 8'h00, 8'h00};
                  endcase
               end
            end
            CMD_REF_SOURCE: begin
               // [R7] Keep upper bits.
               if (s == 3'd1)
                  o = '{OP_READ, DEV_REF_SELECT, 8'h00};
               else if (s == 3'd2)
                  o = '{OP_WRITE, DEV_REF_SELECT,
                        (rb & REF_KEEP_MASK) | (arg[7:0] & ~REF_KEEP_MASK)};
            end
            CMD_TRIG_SOURCE: begin
               // [R8] Hold brackets an initiated change.
               case (s)
                  3'd1: o = '{OP_READ, DEV_TRIG_SELECT, 8'h00};
                  3'd2:
                     if (init)
                        o = '{OP_WRITE, DEV_TRIG_SELECT, rb | TRIG_HOLD_MASK};
                     else
                        o = '{OP_WRITE, DEV_TRIG_SELECT,
                              (rb & TRIG_HOLD_MASK)
                              | (arg[7:0] & ~TRIG_HOLD_MASK)};
                  3'd3: if (init)
                     o = '{OP_WRITE, DEV_TRIG_SELECT,
                           arg[7:0] | TRIG_HOLD_MASK};
                  3'd4: if (init)
                     o = '{OP_WRITE, DEV_TRIG_SELECT,
                           arg[7:0] & ~TRIG_HOLD_MASK};
                  default: o = '{OP_END, 8'h00, 8'h00};
               endcase
            end
            CMD_ARM_NOW: begin
               // [R10] Already armed: nothing to send.
               // [R11] Pre-arm count pending: refuse.
               // [R9] The read itself arms.
               // [R14] Arm moves it to wait-trigger.
               if (st[STATE_ARMED_BIT])
                  o = '{OP_SKIP, 8'h00, 8'h00};
               else if (st[STATE_PREARM_BIT])
                  o = '{OP_REFUSE, 8'h00, 8'h00};
               else if (s == 3'd1)
                  o = '{OP_READ, DEV_ABORT_ARM, 8'h00};
            end
            CMD_TRIG_NOW,
            CMD_ABORT: begin
               // [R12] Trigger-now bracketed by hold.
               // [R13] Abort bracketed by hold.
               case (s)
                  3'd1: o = '{OP_READ, DEV_TRIG_SELECT, 8'h00};
                  3'd2: o = '{OP_WRITE, DEV_TRIG_SELECT,
                              rb | TRIG_HOLD_MASK};
                  3'd3: o = '{OP_WRITE,
                              (c == CMD_ABORT) ? DEV_ABORT_ARM
                                               : DEV_TRIG_NOW, 8'h00};
                  3'd4: o = '{OP_WRITE, DEV_TRIG_SELECT,
                              rb & ~TRIG_HOLD_MASK};
                  default: o = '{OP_END, 8'h00, 8'h00};
               endcase
            end
            default: o = '{OP_END, 8'h00, 8'h00};
         endcase
      end
      return o;
   endfunction

   seq_state_t       state_reg, state_next;
   command_t         cmd_reg;
   logic [2:0]       step_reg;
   logic [7:0]       argLow_reg, argHigh_reg;
   logic             fine_reg;
   logic [7:0]       devState_reg, readBack_reg;
   logic [EV_W-1:0]  events_reg, events_next, mask_reg, eventHits;
   dev_req_t         devReq_reg;
   logic [2:0]       ackSync_reg;
   logic [31:0]      rdata_reg;
   logic             wait_reg, irq_reg;

   // Avalon decode: a request is served in the cycle wait_reg is high and
   // answered one edge later by waitrequest low for exactly one cycle.
   wire logic       busReq     = avsRead | avsWrite;
   wire logic       accept     = busReq & wait_reg;
   wire logic       wrAccept   = accept & avsWrite;
   wire logic       rdAccept   = accept & avsRead;
   wire logic       hitCommand = avsAddress == REG_COMMAND;
   wire logic       hitArgLow  = avsAddress == REG_ARG_LOW;
   wire logic       hitArgHigh = avsAddress == REG_ARG_HIGH;
   wire logic       hitOption  = avsAddress == REG_OPTION;
   wire logic       hitState   = avsAddress == REG_DEV_STATE;
   wire logic       hitEvents  = avsAddress == REG_EVENTS;
   wire logic       hitMask    = avsAddress == REG_MASK;
   wire logic       busy       = state_reg != S_IDLE;
   wire logic       startCmd   = wrAccept & hitCommand & ~busy;
   wire logic       eventsRead = rdAccept & hitEvents;
   wire logic [7:0] busByte    = avsWritedata[7:0];

   // Read mux; bits above each register read as zero.
   wire logic [31:0] readMux =
        hitCommand ? {31'h0, busy}
      : hitArgLow  ? {24'h0, argLow_reg}
      : hitArgHigh ? {24'h0, argHigh_reg}
      : hitOption  ? {31'h0, fine_reg}
      : hitState   ? {24'h0, devState_reg}
      : hitEvents  ? {29'h0, events_reg}
      : hitMask    ? {29'h0, mask_reg}
      : 32'h0;

   // The acknowledge crosses in from the digitizer: only stages 2 and 3
   // are compared, so stage 1 feeds nothing but stage 2.
   wire logic ackOn  = ackSync_reg[1] & ackSync_reg[2];
   wire logic ackOff = ~ackSync_reg[1] & ~ackSync_reg[2];

   // Current step of the running command.
   wire dev_op_t curOp = stepOp(cmd_reg, step_reg, devState_reg,
                                readBack_reg,
                                {argHigh_reg, argLow_reg}, fine_reg);
   wire logic inIssue = state_reg == S_ISSUE;

   // Sequence events; a hit in the same cycle as a clearing read wins.
   always_comb begin
      eventHits              = '0;
      eventHits[EV_DONE]     = inIssue & (curOp.kind == OP_END);
      eventHits[EV_REFUSED]  = inIssue & (curOp.kind == OP_REFUSE);
      eventHits[EV_ARMED]    = inIssue & (curOp.kind == OP_SKIP);
      events_next = (eventsRead ? '0 : events_reg) | eventHits;
   end

   // Sequencer next state; a missing acknowledge stalls it in a wait state,
   // since the digitizer link has no timeout.
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         S_IDLE:
            if (startCmd)
               state_next = S_ISSUE;
         S_ISSUE:
            if (curOp.kind == OP_READ || curOp.kind == OP_WRITE)
               state_next = S_WAIT_ACK;
            else
               state_next = S_IDLE;
         S_WAIT_ACK:
            if (ackOn)
               state_next = S_WAIT_REL;
         S_WAIT_REL:
            if (ackOff)
               state_next = S_ISSUE;
         default:
            state_next = S_IDLE;
      endcase
   end

   // Acknowledge synchroniser.
   always_ff @(posedge clock) begin
      if (srst)
         ackSync_reg <= 3'b000;
      else
         ackSync_reg <= {ackSync_reg[1:0], devAck};
   end

   // Avalon slave answer, event and mask registers.
   always_ff @(posedge clock) begin
      if (srst) begin
         wait_reg   <= 1'b1;
         rdata_reg  <= 32'h0;
         events_reg <= '0;
         mask_reg   <= '0;
         irq_reg    <= 1'b0;
      end else begin
         wait_reg   <= ~accept;
         rdata_reg  <= rdAccept ? readMux : 32'h0;
         events_reg <= events_next;
         if (wrAccept && hitMask)
            mask_reg <= busByte[EV_W-1:0];
         irq_reg    <= |(events_next & mask_reg);
      end
   end

   // Argument registers; a write while busy would change a running step,
   // so those writes are dropped.
   always_ff @(posedge clock) begin
      if (srst) begin
         argLow_reg  <= 8'h00;
         argHigh_reg <= 8'h00;
         fine_reg    <= 1'b0;
      end else if (wrAccept && !busy) begin
         if (hitArgLow)
            argLow_reg <= busByte;
         if (hitArgHigh)
            argHigh_reg <= busByte;
         if (hitOption)
            fine_reg <= busByte[0];
      end
   end

   // Command sequencer and digitizer handshake.
   always_ff @(posedge clock) begin
      if (srst) begin
         state_reg    <= S_IDLE;
         cmd_reg      <= CMD_NOP;
         step_reg     <= 3'd0;
         devState_reg <= 8'h00;
         readBack_reg <= 8'h00;
         devReq_reg   <= '0;
      end else begin
         state_reg <= state_next;
         if (startCmd) begin
            cmd_reg  <= command_t'(busByte[3:0]);
            step_reg <= 3'd0;
         end
         if (inIssue && (curOp.kind == OP_READ || curOp.kind == OP_WRITE))
            devReq_reg <= '{1'b1, curOp.kind == OP_WRITE,
                            curOp.addr, curOp.data};
         if (state_reg == S_WAIT_ACK && ackOn) begin
            devReq_reg.strobe <= 1'b0;
            if (!devReq_reg.write && step_reg == 3'd0)
               devState_reg <= devRdata;
            else if (!devReq_reg.write)
               readBack_reg <= devRdata;
         end
         if (state_reg == S_WAIT_REL && ackOff)
            step_reg <= step_reg + 3'd1;
      end
   end

   assign avsReaddata    = rdata_reg;
   assign avsWaitrequest = wait_reg;
   assign irq            = irq_reg;
   assign devReq         = devReq_reg;

endmodule

// File: verification/arm_seq_chk.sv
// Checker of the arm sequencer controller, watching only its top ports.
// Assumes one clock domain and a synchronous active-high reset.
module arm_seq_chk (
   input wire logic                  clock,
   input wire logic                  srst,
   input wire logic [4:0]            avsAddress,
   input wire logic                  avsRead,
   input wire logic                  avsWrite,
   input wire logic [31:0]           avsWritedata,
   input wire logic [31:0]           avsReaddata,
   input wire logic                  avsWaitrequest,
   input wire logic                  irq,
   input wire arm_seq_pkg::dev_req_t devReq,
   input wire logic [7:0]            devRdata,
   input wire logic                  devAck
);
   timeunit 1ns;
   timeprecision 1ps;
   import arm_seq_pkg::*;

   logic trigHeld;

   // Every property shares the one clock and its reset.
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   // Remember the hold bit last sent to the trigger select register.
   always_ff @(posedge clock) begin
      if (srst)
         trigHeld <= 1'b0;
      else if (devReq.strobe && devReq.write && devReq.addr == DEV_TRIG_SELECT)
         trigHeld <= devReq.wdata[7];
   end

   AST_TAKE_ANSWER: assert property ((avsRead || avsWrite) && avsWaitrequest
      |=> !avsWaitrequest) else $error("Request not answered next cycle.");
   AST_ANSWER_ONE: assert property (!avsWaitrequest |=> avsWaitrequest)
      else $error("Waitrequest low for more than one cycle.");
   AST_NO_UNASKED: assert property (!avsWaitrequest |->
      $past(avsRead || avsWrite)) else $error("Answer without request.");
   AST_IDLE_ZERO: assert property (avsWaitrequest |-> avsReaddata == 32'h0)
      else $error("Read data not zero outside answer.");
   AST_BYTE_WIDE: assert property (avsReaddata[31:8] == 24'h000000)
      else $error("Upper read data bits not zero.");
   AST_STROBE_HOLD: assert property (devReq.strobe && !devAck |=>
      devReq.strobe && $stable(devReq)) else $error("Request changed early.");
   AST_STROBE_ACKED: assert property ($fell(devReq.strobe) |->
      $past(devAck) && $past(devAck, 2)) else $error("Strobe dropped unacked.");
   AST_STROBE_SPACED: assert property ($rose(devReq.strobe) |->
      !$past(devAck) && !$past(devAck, 2)) else $error("Strobe before idle.");
   AST_HOLD_BRACKET: assert property (devReq.strobe && devReq.write &&
      (devReq.addr == DEV_TRIG_NOW || devReq.addr == DEV_ABORT_ARM) |->
      trigHeld) else $error("Strobe write without trigger hold.");
endmodule

bind arm_trigger_sequencer arm_seq_chk i_chk (.clock(clock), .srst(srst),
   .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
   .avsWritedata(avsWritedata), .avsReaddata(avsReaddata),
   .avsWaitrequest(avsWaitrequest), .irq(irq), .devReq(devReq),
   .devRdata(devRdata), .devAck(devAck));

// File: verification/digitizer_model.sv
// Behavioural digitizer register window answering the byte handshake.
// Assumes the bench presets status and registers through hierarchy.
module digitizer_model (
   input wire logic                  clock,
   input wire arm_seq_pkg::dev_req_t devReq,
   output logic [7:0]                devRdata,
   output logic                      devAck,
   input wire logic                  slow
);
   timeunit 1ns;
   timeprecision 1ps;
   import arm_seq_pkg::*;

   logic [7:0]  regs [0:255];
   logic [16:0] opLog [$];
   int          waitCnt;
   int          samples;

   // Start idle with all registers cleared.
   initial begin
      foreach (regs[i]) regs[i] = 8'h00;
      devAck = 1'b0;
      devRdata = 8'h00;
      waitCnt = 0;
      samples = 0;
   end

   // Answer each strobe once; a slow answer exercises the stall path.
   always @(posedge clock) begin
      if (devReq.strobe && !devAck) begin
         waitCnt <= waitCnt + 1;
         if (waitCnt >= (slow ? 8 : 0)) begin
            waitCnt <= 0;
            devAck <= 1'b1;
            devRdata <= regs[devReq.addr];
            opLog.push_back({devReq.write, devReq.addr,
                             devReq.write ? devReq.wdata : 8'h00});
            // Memory and timebase set-up bytes are kept as well.
            if (devReq.write) regs[devReq.addr] <= devReq.wdata;
            if (!devReq.write && devReq.addr == DEV_ABORT_ARM)
               regs[DEV_ARM_STATE][7] <= 1'b1;
            if (devReq.write && devReq.addr == DEV_ABORT_ARM)
               regs[DEV_ARM_STATE] <= 8'h00;
            if (devReq.write && devReq.addr == DEV_TRIG_NOW)
               samples <= samples + 1;
         end
      end else if (!devReq.strobe && devAck) begin
         devAck <= 1'b0;
         devRdata <= ~devRdata; // Released data must not look valid.
      end
   end
endmodule

// File: verification/test_arm_trigger_sequencer.sv
// Self-checking bench of the arm sequencer controller over Avalon-MM.
// Assumes the digitizer model and the bound checker are compiled first.
module test_arm_trigger_sequencer;
   timeunit 1ns;
   timeprecision 1ps;
   import arm_seq_pkg::*;

   localparam logic RD = 1'b0;
   localparam logic WR = 1'b1;

   logic        clock, srst, avsRead, avsWrite, avsWaitrequest, irq;
   logic        devAck, devSlow;
   logic [4:0]  avsAddress;
   logic [31:0] avsWritedata, avsReaddata;
   logic [7:0]  devRdata, q;
   logic [2:0]  maskVal;
   dev_req_t    devReq;
   int          mismatches, checks;

   arm_trigger_sequencer i_dut (.clock(clock), .srst(srst),
      .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
      .avsWritedata(avsWritedata), .avsReaddata(avsReaddata),
      .avsWaitrequest(avsWaitrequest), .irq(irq), .devReq(devReq),
      .devRdata(devRdata), .devAck(devAck));
   digitizer_model i_dev (.clock(clock), .devReq(devReq),
      .devRdata(devRdata), .devAck(devAck), .slow(devSlow));

   // A 40 MHz clock.
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         mismatches++;
         $display("Error at %0t: got %h, expected %h", $time, g, e);
      end
   endtask

   // One Avalon access, held until waitrequest is sampled low.
   task automatic acc(input logic w, input logic [4:0] a,
                      input logic [7:0] d, output logic [7:0] r);
      @(posedge clock);
      avsAddress <= a;
      avsWrite <= w;
      avsRead <= !w;
      avsWritedata <= {24'h000000, d};
      do @(posedge clock); while (avsWaitrequest !== 1'b0);
      r = avsReaddata[7:0];
      avsRead <= 1'b0;
      avsWrite <= 1'b0;
   endtask

   // Next digitizer access must match; reads log zero data.
   task automatic ex(input logic w, input logic [7:0] a, input logic [7:0] d);
      logic [16:0] got;
      got = (i_dev.opLog.size() > 0) ? i_dev.opLog.pop_front() : 17'h1FFFF;
      chk({15'h0000, got}, {15'h0000, w, a, d});
   endtask

   // Issue a command, wait for idle, then check interrupt and event.
   task automatic run(input command_t op, input logic [15:0] arg,
                      input logic opt, input logic [2:0] ev);
      logic [7:0] r;
      int         n;
      chk(i_dev.opLog.size(), 0);
      acc(WR, REG_ARG_LOW, arg[7:0], r);
      chk({31'h0, irq}, 0);
      acc(WR, REG_ARG_HIGH, arg[15:8], r);
      acc(WR, REG_OPTION, {7'h00, opt}, r);
      acc(WR, REG_COMMAND, {4'h0, op}, r);
      n = 0;
      r = 8'h01;
      while (r[0] !== 1'b0 && n < 400) begin
         acc(RD, REG_COMMAND, 8'h00, r);
         n++;
      end
      chk({31'h0, r[0]}, 32'h0);
      @(posedge clock);
      chk({31'h0, irq}, {31'h0, |(ev & maskVal)});
      acc(RD, REG_EVENTS, 8'h00, r);
      chk({24'h0, r}, {29'h0, ev});
      ex(RD, DEV_ARM_STATE, 8'h00);
   endtask

   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Cut a hang short well past the expected run length.
   initial begin
      repeat (30000) @(posedge clock);
      mismatches++;
      wrap_up;
   end

   // Main sequence; the model's status byte sets idle or initiated.
   initial begin
      {srst, avsRead, avsWrite, devSlow} = 4'b1000;
      avsAddress = 5'h00;
      avsWritedata = 32'h0;
      mismatches = 0;
      checks = 0;
      maskVal = 3'h3;
      repeat (5) @(posedge clock);
      srst <= 1'b0;
      acc(RD, 5'h1C, 8'h00, q);
      chk({24'h0, q}, 0);
      acc(WR, REG_EVENTS, 8'h07, q);
      acc(RD, REG_EVENTS, 8'h00, q);
      chk({24'h0, q}, 0);
      acc(WR, REG_MASK, 8'h03, q);
      run(CMD_ARM_SOURCE, 16'h0012, 1'b0, 3'h1);
      ex(WR, DEV_ARM_SOURCE, 8'h12);
      i_dev.regs[DEV_ARM_STATE] = 8'h02;
      i_dev.regs[DEV_ARM_CONTROL] = 8'h31;
      devSlow <= 1'b1;
      run(CMD_ARM_SOURCE, 16'h0007, 1'b0, 3'h1);
      ex(RD, DEV_ARM_CONTROL, 8'h00);
      ex(WR, DEV_ARM_CONTROL, 8'h35);
      ex(WR, DEV_ARM_SOURCE, 8'h07);
      ex(WR, DEV_ARM_CONTROL, 8'h31);
      run(CMD_ARM_COUNT, 16'h012C, 1'b0, 3'h2);
      devSlow <= 1'b0;
      i_dev.regs[DEV_ARM_STATE] = 8'h00;
      run(CMD_ARM_COUNT, 16'h012C, 1'b0, 3'h1);
      ex(WR, DEV_COUNT_HIGH, 8'h01);
      ex(WR, DEV_COUNT_LOW, 8'h2C);
      run(CMD_ARM_COUNT, 16'h0000, 1'b0, 3'h2);
      i_dev.regs[DEV_ARM_CONTROL] = 8'h30;
      run(CMD_ARM_DELAY, 16'h4E20, 1'b1, 3'h1);
      ex(RD, DEV_ARM_CONTROL, 8'h00);
      ex(WR, DEV_ARM_CONTROL, 8'h31);
      ex(WR, DEV_DELAY_HIGH, 8'h4E);
      ex(WR, DEV_DELAY_LOW, 8'h21);
      run(CMD_ARM_DELAY, 16'h00FF, 1'b0, 3'h1);
      ex(RD, DEV_ARM_CONTROL, 8'h00);
      ex(WR, DEV_ARM_CONTROL, 8'h30);
      ex(WR, DEV_DELAY_HIGH, 8'h01);
      ex(WR, DEV_DELAY_LOW, 8'h00);
      run(CMD_ARM_DELAY, 16'hFFFF, 1'b1, 3'h2);
      i_dev.regs[DEV_REF_SELECT] = 8'hA9;
      run(CMD_REF_SOURCE, 16'h0006, 1'b0, 3'h1);
      ex(RD, DEV_REF_SELECT, 8'h00);
      ex(WR, DEV_REF_SELECT, 8'hAE);
      i_dev.regs[DEV_TRIG_SELECT] = 8'h85;
      run(CMD_TRIG_SOURCE, 16'h001C, 1'b0, 3'h1);
      ex(RD, DEV_TRIG_SELECT, 8'h00);
      ex(WR, DEV_TRIG_SELECT, 8'h9C);
      i_dev.regs[DEV_ARM_STATE] = 8'h02;
      i_dev.regs[DEV_TRIG_SELECT] = 8'h05;
      run(CMD_TRIG_SOURCE, 16'h0011, 1'b0, 3'h1);
      ex(RD, DEV_TRIG_SELECT, 8'h00);
      ex(WR, DEV_TRIG_SELECT, 8'h85);
      ex(WR, DEV_TRIG_SELECT, 8'h91);
      ex(WR, DEV_TRIG_SELECT, 8'h11);
      acc(WR, REG_MASK, 8'h07, q);
      acc(RD, REG_MASK, 8'h00, q);
      chk({24'h0, q}, 32'h07);
      maskVal = 3'h7;
      i_dev.regs[DEV_ARM_STATE] = 8'h80;
      run(CMD_ARM_NOW, 16'h0000, 1'b0, 3'h4);
      i_dev.regs[DEV_ARM_STATE] = 8'h22;
      run(CMD_ARM_NOW, 16'h0000, 1'b0, 3'h2);
      i_dev.regs[DEV_ARM_STATE] = 8'h02;
      run(CMD_ARM_NOW, 16'h0000, 1'b0, 3'h1);
      ex(RD, DEV_ABORT_ARM, 8'h00);
      run(CMD_READ_STATE, 16'h0000, 1'b0, 3'h1);
      acc(RD, REG_DEV_STATE, 8'h00, q);
      chk({24'h0, q}, 32'h82);
      i_dev.regs[DEV_TRIG_SELECT] = 8'h15;
      run(CMD_TRIG_NOW, 16'h0000, 1'b0, 3'h1);
      ex(RD, DEV_TRIG_SELECT, 8'h00);
      ex(WR, DEV_TRIG_SELECT, 8'h95);
      ex(WR, DEV_TRIG_NOW, 8'h00);
      ex(WR, DEV_TRIG_SELECT, 8'h15);
      chk(i_dev.samples, 1);
      run(CMD_ABORT, 16'h0000, 1'b0, 3'h1);
      ex(RD, DEV_TRIG_SELECT, 8'h00);
      ex(WR, DEV_TRIG_SELECT, 8'h95);
      ex(WR, DEV_ABORT_ARM, 8'h00);
      ex(WR, DEV_TRIG_SELECT, 8'h15);
      run(CMD_READ_STATE, 16'h0000, 1'b0, 3'h1);
      acc(RD, REG_DEV_STATE, 8'h00, q);
      chk({24'h0, q}, 0);
      run(CMD_NOP, 16'h0000, 1'b0, 3'h1);
      chk(i_dev.opLog.size(), 0);
      wrap_up;
   end
endmodule
